// ### logic/hia_pkg.sv
// Shared constants, types and helpers of the host interrupt aggregator
package hia_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SRC_N  = 9;
  localparam int unsigned ST_N   = 3;

  typedef logic [SRC_N-1:0]  hia_src_t;
  typedef logic [ST_N-1:0]   hia_st_t;
  typedef logic [ADDR_W-1:0] hia_addr_t;
  typedef logic [DATA_W-1:0] hia_data_t;

  // Register byte offsets
  localparam hia_addr_t OFS_PIN_ENABLE  = 8'h00;
  localparam hia_addr_t OFS_PENDING     = 8'h04;
  localparam hia_addr_t OFS_SOURCE_MASK = 8'h08;
  localparam hia_addr_t OFS_PIN_CONFIG  = 8'h0c;
  localparam hia_addr_t OFS_IRQ_STATUS  = 8'h10;
  localparam hia_addr_t OFS_IRQ_MASK    = 8'h14;

  // Pending flag positions
  localparam int unsigned BIT_SWAP       = 0;
  localparam int unsigned BIT_TOUCH      = 1;
  localparam int unsigned BIT_TAG        = 2;
  localparam int unsigned BIT_SOUND      = 3;
  localparam int unsigned BIT_PLAYBACK   = 4;
  localparam int unsigned BIT_CMD_EMPTY  = 5;
  localparam int unsigned BIT_CMD_FLAG   = 6;
  localparam int unsigned BIT_CONV_DONE  = 7;
  localparam int unsigned BIT_UNDERRUN   = 8;

  // Field positions of the own control and status registers
  localparam int unsigned CFG_PUSH_PULL  = 0;
  localparam int unsigned ST_PIN_ASSERT  = 0;
  localparam int unsigned ST_OVERFLOW    = 1;
  localparam int unsigned ST_BUS_ERR     = 2;

  // Values after reset
  localparam logic     RST_PIN_ENABLE = 1'b0;
  localparam logic     RST_PUSH_PULL  = 1'b0;
  localparam hia_src_t RST_PENDING    = 9'h000;
  localparam hia_src_t RST_MASK       = 9'h000;
  localparam hia_st_t  RST_STATUS     = 3'h0;
  localparam hia_st_t  RST_IRQ_MASK   = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  function automatic logic hia_hit(input hia_addr_t addr, input hia_addr_t ofs);
    return addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction : hia_hit

  function automatic hia_data_t hia_lanes(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : hia_lanes

  function automatic hia_data_t hia_merge(input hia_data_t old, input hia_data_t wd, input logic [3:0] strb);
    return (old & ~hia_lanes(strb)) | (wd & hia_lanes(strb));
  endfunction : hia_merge

endpackage : hia_pkg

// ### logic/hia_flag_if.sv
// Carrier between the aggregator and its pending flag store
`timescale 1ns/1ps
`default_nettype none
interface hia_flag_if;
  import hia_pkg::*;
  hia_src_t set;
  logic     clr;
  hia_src_t flags;
  logic     ovf;
  modport ctl   (output set, output clr, input flags, input ovf);
  modport store (input set, input clr, output flags, output ovf);
endinterface : hia_flag_if
`default_nettype wire

// ### logic/hia_pending.sv
// Sticky pending flags, cleared as a whole by a host read
`timescale 1ns/1ps
`default_nettype none
module hia_pending (
  input wire logic    aclk,
  input wire logic    aresetn,
  hia_flag_if.store   fl
);
  import hia_pkg::*;

  hia_src_t flags_reg;
  hia_src_t flags_next;

  // Each source sets only its own bit; a set in the clearing cycle survives
  assign flags_next = (fl.clr ? RST_PENDING : flags_reg) | fl.set;
  assign fl.flags   = flags_reg;
  // An event on an already pending flag merges with it and raises the overflow output, except in a clearing cycle
  assign fl.ovf     = |(fl.set & flags_reg & ~{SRC_N{fl.clr}});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= RST_PENDING;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule : hia_pending
`default_nettype wire

// ### logic/hia_pin_drv.sv
// Output stage of the active-low host interrupt pin
`timescale 1ns/1ps
`default_nettype none
module hia_pin_drv (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic drive_en,
  input  wire logic assert_req,
  input  wire logic push_pull,
  output var  logic pin_n_o,
  output var  logic pin_n_oe
);
  import hia_pkg::*;

  logic oe_next;
  logic o_next;

  // Open drain drives only the low level; push-pull drives both while enabled
  assign oe_next = drive_en & (push_pull | assert_req);
  assign o_next  = ~(drive_en & assert_req);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_n_oe <= 1'b0;
      pin_n_o  <= 1'b1;
    end else begin
      pin_n_oe <= oe_next;
      pin_n_o  <= o_next;
    end
  end

endmodule : hia_pin_drv
`default_nettype wire

// ### logic/hia_aggregator.sv
// Host interrupt aggregator: pending flags, mask, enable and pin drive behind AXI4-Lite
//
// How it works
// - Only the global pin enable bit lets the interrupt pin be driven at all.
// - With the global enable at 0 the pin is released and the external pull-up holds it high.
// - With the enable at 1 the pin goes low while any pending flag whose mask bit is set is high.
// - A mask bit of 1 lets its pending flag reach the pin, a mask bit of 0 blocks it.
// - Each pending flag is set by its own source event, independent of the others.
// - The pending flags can be read at any time, and the read returns them and then clears them all.
// - Out of reset the pin works open drain, pulling low only and never driving high.
// - A bit in the extended pin configuration register switches the pin to push-pull drive.
// - Flag 0 is display list swap done, flag 1 is touch detected, flag 3 is sound effect ended.
// - Flag 2 is touch tag change, flag 4 is audio playback ended, flag 7 is touch conversions done.
// - Flag 5 is command queue empty, flag 6 is command queue flag, flag 8 is pipeline underrun.
`timescale 1ns/1ps
`default_nettype none
module hia_aggregator (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire hia_pkg::hia_addr_t s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire hia_pkg::hia_data_t s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire hia_pkg::hia_addr_t s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  hia_pkg::hia_data_t s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Source events, one-cycle pulses from logic on aclk
  input  wire logic              swap_done_event,
  input  wire logic              touch_event,
  input  wire logic              tag_change_event,
  input  wire logic              sound_done_event,
  input  wire logic              playback_done_event,
  input  wire logic              cmd_queue_empty_event,
  input  wire logic              cmd_queue_flag_event,
  input  wire logic              touch_conv_done_event,
  input  wire logic              underrun_event,
  // Host interrupt pin, active low
  output var  logic              host_irq_n_o,
  output var  logic              host_irq_n_oe,
  // Level interrupt of the block's own status
  output var  logic              irq
);
  import hia_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  hia_addr_t  awaddr_reg;
  hia_data_t  wdata_reg;
  logic [3:0] wstrb_reg;
  logic       aw_full_reg;
  logic       aw_full_next;
  logic       w_full_reg;
  logic       w_full_next;
  logic       awready_reg;
  logic       wready_reg;
  logic       bvalid_reg;
  logic       bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic       arready_reg;
  logic       rvalid_reg;
  logic       rvalid_next;
  hia_data_t  rdata_reg;
  hia_data_t  rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  logic       pin_enable_reg;
  logic       pin_enable_next;
  hia_src_t   source_mask_reg;
  hia_src_t   source_mask_next;
  logic       push_pull_reg;
  logic       push_pull_next;
  hia_st_t    status_reg;
  hia_st_t    status_next;
  hia_st_t    status_set;
  hia_st_t    status_w1c;
  hia_st_t    irq_mask_reg;
  hia_st_t    irq_mask_next;
  logic       irq_reg;
  logic       irq_next;
  logic       asserted_d_reg;

  hia_flag_if fl ();

  // ************************************************************
  // Write channel
  // ************************************************************
  wire aw_hs  = s_axi_awvalid & awready_reg;
  wire w_hs   = s_axi_wvalid & wready_reg;
  wire b_hs   = bvalid_reg & s_axi_bready;
  // Address and data may come in either order; the write waits for both
  wire wr_go  = aw_full_reg & w_full_reg & ~bvalid_reg;

  wire wr_pin_en  = wr_go & hia_hit(awaddr_reg, OFS_PIN_ENABLE);
  wire wr_pending = wr_go & hia_hit(awaddr_reg, OFS_PENDING);
  wire wr_mask    = wr_go & hia_hit(awaddr_reg, OFS_SOURCE_MASK);
  wire wr_cfg     = wr_go & hia_hit(awaddr_reg, OFS_PIN_CONFIG);
  wire wr_status  = wr_go & hia_hit(awaddr_reg, OFS_IRQ_STATUS);
  wire wr_irq_msk = wr_go & hia_hit(awaddr_reg, OFS_IRQ_MASK);
  // Pending flags are read-only; a write there is accepted and has no effect
  wire wr_mapped  = wr_pin_en | wr_pending | wr_mask | wr_cfg | wr_status | wr_irq_msk;
  wire wr_error   = wr_go & ~wr_mapped;

  assign aw_full_next = (aw_full_reg | aw_hs) & ~wr_go;
  assign w_full_next  = (w_full_reg | w_hs) & ~wr_go;
  assign bvalid_next  = wr_go | (bvalid_reg & ~b_hs);
  assign bresp_next   = wr_go ? (wr_mapped ? RESP_OKAY : RESP_SLVERR) : bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= ~aw_full_next;
      wready_reg  <= ~w_full_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // Payload holders carry no control meaning, so they skip the reset
  always_ff @(posedge aclk) begin
    if (aw_hs) begin
      awaddr_reg <= s_axi_awaddr;
    end
    if (w_hs) begin
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
  end

  // ************************************************************
  // Register file
  // ************************************************************
  wire hia_data_t pin_enable_wm = hia_merge(32'(pin_enable_reg), wdata_reg, wstrb_reg);
  wire hia_data_t mask_wm       = hia_merge(32'(source_mask_reg), wdata_reg, wstrb_reg);
  wire hia_data_t cfg_wm        = hia_merge(32'(push_pull_reg), wdata_reg, wstrb_reg);
  wire hia_data_t irq_mask_wm   = hia_merge(32'(irq_mask_reg), wdata_reg, wstrb_reg);
  wire hia_data_t status_ones   = wdata_reg & hia_lanes(wstrb_reg);

  assign pin_enable_next  = wr_pin_en ? pin_enable_wm[0] : pin_enable_reg;
  assign source_mask_next = wr_mask ? mask_wm[SRC_N-1:0] : source_mask_reg;
  assign push_pull_next   = wr_cfg ? cfg_wm[CFG_PUSH_PULL] : push_pull_reg;
  assign irq_mask_next    = wr_irq_msk ? irq_mask_wm[ST_N-1:0] : irq_mask_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_enable_reg  <= RST_PIN_ENABLE;
      source_mask_reg <= RST_MASK;
      push_pull_reg   <= RST_PUSH_PULL;
      irq_mask_reg    <= RST_IRQ_MASK;
    end else begin
      pin_enable_reg  <= pin_enable_next;
      source_mask_reg <= source_mask_next;
      push_pull_reg   <= push_pull_next;
      irq_mask_reg    <= irq_mask_next;
    end
  end

  // ************************************************************
  // Pending flags
  // ************************************************************
  // One process drives the whole vector, so the set word has a single driver
  always_comb begin
    fl.set                = '0;
    fl.set[BIT_SWAP]      = swap_done_event;
    fl.set[BIT_TOUCH]     = touch_event;
    fl.set[BIT_SOUND]     = sound_done_event;
    fl.set[BIT_TAG]       = tag_change_event;
    fl.set[BIT_PLAYBACK]  = playback_done_event;
    fl.set[BIT_CONV_DONE] = touch_conv_done_event;
    fl.set[BIT_CMD_EMPTY] = cmd_queue_empty_event;
    fl.set[BIT_CMD_FLAG]  = cmd_queue_flag_event;
    fl.set[BIT_UNDERRUN]  = underrun_event;
  end

  hia_pending u_pending (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fl      (fl.store)
  );

  // ************************************************************
  // Read channel
  // ************************************************************
  wire ar_hs      = s_axi_arvalid & arready_reg;
  wire r_hs       = rvalid_reg & s_axi_rready;
  wire rd_pin_en  = hia_hit(s_axi_araddr, OFS_PIN_ENABLE);
  wire rd_pending = hia_hit(s_axi_araddr, OFS_PENDING);
  wire rd_mask    = hia_hit(s_axi_araddr, OFS_SOURCE_MASK);
  wire rd_cfg     = hia_hit(s_axi_araddr, OFS_PIN_CONFIG);
  wire rd_status  = hia_hit(s_axi_araddr, OFS_IRQ_STATUS);
  wire rd_irq_msk = hia_hit(s_axi_araddr, OFS_IRQ_MASK);
  wire rd_mapped  = rd_pin_en | rd_pending | rd_mask | rd_cfg | rd_status | rd_irq_msk;
  wire rd_error   = ar_hs & ~rd_mapped;

  wire hia_data_t rd_mux =
    rd_pin_en  ? 32'(pin_enable_reg)  :
    rd_pending ? 32'(fl.flags)        :
    rd_mask    ? 32'(source_mask_reg) :
    rd_cfg     ? 32'(push_pull_reg)   :
    rd_status  ? 32'(status_reg)      :
    rd_irq_msk ? 32'(irq_mask_reg)    :
    32'h0000_0000;

  // The flags are captured and cleared on the same edge, so nothing is read twice
  assign fl.clr      = ar_hs & rd_pending;
  assign rvalid_next = ar_hs | (rvalid_reg & ~r_hs);
  assign rdata_next  = ar_hs ? rd_mux : rdata_reg;
  assign rresp_next  = ar_hs ? (rd_mapped ? RESP_OKAY : RESP_SLVERR) : rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ************************************************************
  // Pin and status
  // ************************************************************
  // Masked flags decide the request; the enable is applied in the pin stage
  wire any_masked = |(fl.flags & source_mask_reg);
  wire asserted   = pin_enable_reg & any_masked;

  hia_pin_drv u_pin (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .drive_en   (pin_enable_reg),
    .assert_req (any_masked),
    .push_pull  (push_pull_reg),
    .pin_n_o    (host_irq_n_o),
    .pin_n_oe   (host_irq_n_oe)
  );

  assign status_set[ST_PIN_ASSERT] = asserted & ~asserted_d_reg;
  assign status_set[ST_OVERFLOW]   = fl.ovf;
  assign status_set[ST_BUS_ERR]    = wr_error | rd_error;
  assign status_w1c = wr_status ? status_ones[ST_N-1:0] : RST_STATUS;
  // Set beats write-one-to-clear so that no event slips through
  assign status_next = (status_reg & ~status_w1c) | status_set;
  assign irq_next    = |(status_next & irq_mask_next);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg     <= RST_STATUS;
      asserted_d_reg <= 1'b0;
      irq_reg        <= 1'b0;
    end else begin
      status_reg     <= status_next;
      asserted_d_reg <= asserted;
      irq_reg        <= irq_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign irq           = irq_reg;

endmodule : hia_aggregator
`default_nettype wire

// ### logic/_end.sv
// (intentionally minimal)

// ### sim/hia_host_model.sv
// Host side interrupt input of the aggregator pin, with the board pull-up
`timescale 1ns/1ps
`default_nettype none
module hia_host_model (
  input  wire logic pin_n_o,
  input  wire logic pin_n_oe,
  output var  logic line_n,
  output var  logic pp_drive_high
);
  // A released line floats up through the pull-up, never to a stale level
  assign line_n        = pin_n_oe ? pin_n_o : 1'b1;
  assign pp_drive_high = pin_n_oe && pin_n_o;
endmodule : hia_host_model
`default_nettype wire

// ### sim/hia_aggregator_checker.sv
// Concurrent checks on the ports of the host interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module hia_aggregator_checker (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire hia_pkg::hia_addr_t s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire hia_pkg::hia_data_t s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               swap_done_event,
  input wire logic               touch_event,
  input wire logic               tag_change_event,
  input wire logic               sound_done_event,
  input wire logic               playback_done_event,
  input wire logic               cmd_queue_empty_event,
  input wire logic               cmd_queue_flag_event,
  input wire logic               touch_conv_done_event,
  input wire logic               underrun_event,
  input wire logic               host_irq_n_o,
  input wire logic               host_irq_n_oe
);
  import hia_pkg::*;
  // ****************
  // Pending flag model
  // ****************
  hia_src_t ev;
  hia_src_t fl;
  hia_src_t snap;
  logic     rd_pend;
  logic     pend_rd;
  assign ev = {underrun_event, touch_conv_done_event, cmd_queue_flag_event, cmd_queue_empty_event,
               playback_done_event, sound_done_event, tag_change_event, touch_event, swap_done_event};
  assign pend_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == OFS_PENDING[7:2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl      <= '0;
      snap    <= '0;
      rd_pend <= 1'b0;
    end else begin
      // An event in the clearing cycle survives the read
      fl <= pend_rd ? ev : (fl | ev);
      if (s_axi_arvalid && s_axi_arready) begin
        snap    <= fl;
        rd_pend <= pend_rd;
      end
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_RST_PIN: assert property ($rose(aresetn) |-> !host_irq_n_oe && host_irq_n_o)
    else $error("pin not released after reset");
  AST_NO_REQ_NO_PIN: assert property ($past(aresetn) && $past(fl) == '0 |-> !(host_irq_n_oe && !host_irq_n_o))
    else $error("pin pulled low with no pending flag");
  AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_PEND_DATA: assert property ($rose(s_axi_rvalid) && rd_pend |-> s_axi_rdata == hia_data_t'(snap))
    else $error("pending read data wrong");
  AST_ARREADY_LOW: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read accepted while answer open");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not withdrawn");
  AST_B_LATENCY: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not withdrawn");
endmodule : hia_aggregator_checker

bind hia_aggregator hia_aggregator_checker u_checker (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .swap_done_event, .touch_event, .tag_change_event, .sound_done_event,
  .playback_done_event, .cmd_queue_empty_event, .cmd_queue_flag_event, .touch_conv_done_event,
  .underrun_event, .host_irq_n_o, .host_irq_n_oe
);
`default_nettype wire

// ### sim/host_irq_aggregator_test.sv
// Self-checking bench of the host interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module host_irq_aggregator_test;
  import hia_pkg::*;
  logic      aclk = 1'b0;
  logic      aresetn = 1'b0;
  hia_addr_t s_axi_awaddr = '0;
  hia_addr_t s_axi_araddr = '0;
  hia_data_t s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [3:0] strb = 4'hf;
  logic      s_axi_awvalid = 1'b0;
  logic      s_axi_wvalid = 1'b0;
  logic      s_axi_bready = 1'b0;
  logic      s_axi_arvalid = 1'b0;
  logic      s_axi_rready = 1'b0;
  hia_src_t  ev = '0;
  hia_src_t  fl = '0;
  hia_src_t  msk = '0;
  logic [31:0] seed = 32'h34;
  int        n_mismatch = 0;
  int        n_compared = 0;
  int        cyc = 0;
  logic      s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  hia_data_t s_axi_rdata;
  logic      pin_o, pin_oe, irq, line_n, pp_high;

  always #20 aclk = ~aclk;

  hia_aggregator dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .swap_done_event(ev[0]), .touch_event(ev[1]), .sound_done_event(ev[3]),
    .tag_change_event(ev[2]), .playback_done_event(ev[4]), .touch_conv_done_event(ev[7]),
    .cmd_queue_empty_event(ev[5]), .cmd_queue_flag_event(ev[6]), .underrun_event(ev[8]),
    .host_irq_n_o(pin_o), .host_irq_n_oe(pin_oe), .irq(irq)
  );
  hia_host_model host (.pin_n_o(pin_o), .pin_n_oe(pin_oe), .line_n(line_n), .pp_drive_high(pp_high));

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input hia_addr_t a, input hia_data_t d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk("bresp", s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  // The event in e is offered exactly at the edge that takes the read
  task automatic rd(input hia_addr_t a, input hia_src_t e, input logic [1:0] er, output hia_data_t d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ev <= e;
    while (!done) begin
      @(posedge aclk);
      ev <= '0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        chk("rresp", s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  task automatic rdp(input hia_src_t e);
    hia_data_t d;
    rd(OFS_PENDING, e, RESP_OKAY, d);
    chk("pending", d, fl);
    fl = e;
  endtask : rdp

  task automatic pulse(input hia_src_t e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= '0;
    fl = fl | e;
  endtask : pulse

  task automatic pin_chk(input logic en, input logic pp);
    logic req;
    req = en && ((fl & msk) != '0);
    repeat (3) @(posedge aclk);
    chk("pin_oe", pin_oe, en && (pp || req));
    chk("line", line_n, !req);
    chk("drive_high", pp_high, en && pp && !req);
  endtask : pin_chk

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // Ceiling is several times the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    hia_data_t d;
    int i;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    pin_chk(1'b0, 1'b0);
    for (i = 0; i < 6; i++) begin
      rd(hia_addr_t'(i * 4), '0, RESP_OKAY, d);
      chk("reset value", d, '0);
    end
    wr(OFS_SOURCE_MASK, 32'hffffffff, RESP_OKAY);
    msk = 9'h1ff;
    rd(OFS_SOURCE_MASK, '0, RESP_OKAY, d);
    chk("mask", d, 32'h1ff);
    // Only lane 1 written: flag 8 masked off, lane 0 kept
    strb = 4'h2;
    wr(OFS_SOURCE_MASK, 32'h0, RESP_OKAY);
    strb = 4'hf;
    msk = 9'h0ff;
    rd(OFS_SOURCE_MASK, '0, RESP_OKAY, d);
    chk("mask lanes", d, 32'h0ff);
    // Disabled pin must stay released whatever the flags
    for (i = 0; i < 9; i++) begin
      pulse(hia_src_t'(1 << i));
      pin_chk(1'b0, 1'b0);
      rdp('0);
      rdp('0);
    end
    wr(OFS_PIN_ENABLE, 32'h1, RESP_OKAY);
    for (i = 0; i < 24; i++) begin
      if (i == 12) wr(OFS_PIN_CONFIG, 32'h1, RESP_OKAY);
      msk = hia_src_t'(xs());
      wr(OFS_SOURCE_MASK, 32'(msk), RESP_OKAY);
      pulse(hia_src_t'(xs()));
      pin_chk(1'b1, i >= 12);
      rdp(i[0] ? hia_src_t'(xs()) : '0);
    end
    rd(8'h18, '0, RESP_SLVERR, d);
    chk("unmapped", d, '0);
    wr(8'h1c, 32'h1, RESP_SLVERR);
    chk("irq masked", irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h4, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 1'b1);
    wr(OFS_IRQ_STATUS, 32'h4, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq cleared", irq, 1'b0);
    // Directed status: request rising, then an event on a pending flag
    wr(OFS_SOURCE_MASK, 32'h1, RESP_OKAY);
    msk = 9'h001;
    rdp('0);
    wr(OFS_IRQ_STATUS, 32'h7, RESP_OKAY);
    pulse(9'h001);
    pulse(9'h001);
    // A write to the pending flags must not clear them
    wr(OFS_PENDING, 32'h0, RESP_OKAY);
    rd(OFS_IRQ_STATUS, '0, RESP_OKAY, d);
    chk("status", d, 32'h3);
    pin_chk(1'b1, 1'b1);
    rdp('0);
    conclude();
  end
endmodule : host_irq_aggregator_test
`default_nettype wire
